/* File: rtl/pcl_loader.sv */
// configuration image loader for the port setup fields
//
// The Wishbone interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module pcl_loader
	import pcl_pkg::*;
(
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	input  wire logic                      wb_cyc_i,
	input  wire logic                      wb_stb_i,
	input  wire logic                      wb_we_i,
	input  wire logic [WB_AW-1:0]          wb_adr_i,
	input  wire logic [3:0]                wb_sel_i,
	input  wire logic [31:0]               wb_dat_i,
	output logic      [31:0]               wb_dat_o,
	output logic                           wb_ack_o,
	output logic                           img_req_o,
	output logic      [IMG_AW-1:0]         img_addr_o,
	input  wire logic                      img_ack_i,
	input  wire logic [IMG_DW-1:0]         img_data_i,
	output pcl_port_cfg_t [NPORT-1:0]      cfg_o,
	output logic                           cfg_valid_o
);

	pcl_state_t                state;
	pcl_state_t                next_state;
	logic [STEP_W-1:0]         step;
	logic [STEP_W-1:0]         next_step;
	logic                      start_pend;
	logic                      next_start_pend;
	logic [15:0]               load_cnt;
	logic [15:0]               next_load_cnt;
	logic                      next_img_req;
	logic [IMG_AW-1:0]         next_img_addr;
	logic                      next_cfg_valid;
	pcl_port_cfg_t [NPORT-1:0] next_cfg;
	logic                      next_ack;
	logic [31:0]               next_dat;
	logic                      wb_req;
	logic                      take;

	function automatic logic [IMG_AW-1:0] step_addr(input logic [STEP_W-1:0] s);
		case (s)
			3'h0:    step_addr = IMG_LINK_P0;
			3'h1:    step_addr = IMG_LINK_P1;
			3'h2:    step_addr = IMG_LINK_P2;
			3'h3:    step_addr = IMG_AMP;
			3'h4:    step_addr = IMG_DEEMPH;
			3'h5:    step_addr = IMG_PHY;
			3'h6:    step_addr = IMG_SLOT_P0;
			default: step_addr = IMG_SLOT_P1;
		endcase
	endfunction

	// only named fields are copied; reserved image bits fall away here
	function automatic pcl_port_cfg_t load_link(input pcl_port_cfg_t c, input pcl_link_word_t w);
		pcl_port_cfg_t r;
		r           = c;
		r.fts_count = w.fts_count;
		r.ppm_diff  = w.ppm_diff;
		r.scrambler = w.scrambler;
		r.l0s       = w.l0s;
		load_link   = r;
	endfunction

	function automatic pcl_port_cfg_t load_slot(input pcl_port_cfg_t c, input pcl_slot_word_t w);
		pcl_port_cfg_t r;
		r             = c;
		r.slot_clock  = w.slot_clock;
		r.dev_init    = w.dev_init;
		r.port_number = w.port_number;
		r.pm_scale    = w.pm_scale;
		r.tc_map      = w.tc_map;
		load_slot     = r;
	endfunction

	function automatic logic [31:0] port_word(input pcl_port_cfg_t c, input logic hi);
		logic [63:0] wide;
		wide      = 64'(c);
		port_word = hi ? wide[63:32] : wide[31:0];
	endfunction

	assign wb_req = wb_cyc_i & wb_stb_i;
	assign take   = (state == ST_FETCH) & img_req_o & img_ack_i;

	// loader sequence
	always_comb begin
		pcl_amp_word_t    aw;
		pcl_deemph_word_t dw;
		pcl_phy_word_t    pw;
		pcl_slot_word_t   sw;
		aw              = pcl_amp_word_t'(img_data_i);
		dw              = pcl_deemph_word_t'(img_data_i);
		pw              = pcl_phy_word_t'(img_data_i);
		sw              = pcl_slot_word_t'(img_data_i);
		next_state      = state;
		next_step       = step;
		next_start_pend = start_pend;
		next_load_cnt   = load_cnt;
		next_img_req    = 1'b0;
		next_img_addr   = img_addr_o;
		next_cfg_valid  = cfg_valid_o;
		next_cfg        = cfg_o;
		// reload requested over the bus; ignored while a load runs
		if (wb_req && wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == REG_CTRL
				&& wb_dat_i[CTRL_RELOAD] && state == ST_IDLE) begin
			next_start_pend = 1'b1;
		end
		case (state)
			ST_IDLE: begin
				if (start_pend) begin
					next_start_pend = 1'b0;
					next_state      = ST_FETCH;
					next_step       = '0;
					next_img_req    = 1'b1;
					next_img_addr   = step_addr('0);
					next_cfg_valid  = 1'b0;
				end
			end
			ST_FETCH: begin
				next_img_req = 1'b1;
				if (take) begin
					case (img_addr_o)
						IMG_LINK_P0: next_cfg[0] = load_link(cfg_o[0], img_data_i);
						IMG_LINK_P1: next_cfg[1] = load_link(cfg_o[1], img_data_i);
						IMG_LINK_P2: next_cfg[2] = load_link(cfg_o[2], img_data_i);
						IMG_AMP: begin
							for (int p = 0; p < NPORT; p++) begin
								next_cfg[p].drive_amplitude_nominal_low  = aw.nominal_low;
								next_cfg[p].drive_amplitude_nominal_high = aw.nominal_high;
								next_cfg[p].amp_half                     = aw.half;
							end
						end
						IMG_DEEMPH: begin
							for (int p = 0; p < NPORT; p++) begin
								next_cfg[p].deemph = dw.level;
							end
						end
						IMG_PHY: begin
							for (int p = 0; p < NPORT; p++) begin
								next_cfg[p].phy_latency = pw.phy_latency;
								next_cfg[p].rx_detect   = pw.rx_detect;
							end
						end
						IMG_SLOT_P0: next_cfg[0] = load_slot(cfg_o[0], img_data_i);
						IMG_SLOT_P1: begin
							next_cfg[1]           = load_slot(cfg_o[1], img_data_i);
							next_cfg[1].slot_impl = sw.slot_impl;
						end
						default: ;
					endcase
					if (step == STEP_W'(NSTEP - 1)) begin
						next_state     = ST_IDLE;
						next_img_req   = 1'b0;
						next_cfg_valid = 1'b1;
						next_load_cnt  = load_cnt + 16'h0001;
					end else begin
						next_step     = step + 3'h1;
						next_img_addr = step_addr(step + 3'h1);
					end
				end
			end
			default: begin
				next_state   = ST_IDLE;
				next_img_req = 1'b0;
			end
		endcase
	end

	// first load starts by itself after reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state       <= ST_IDLE;
			step        <= '0;
			start_pend  <= 1'b1;
			load_cnt    <= '0;
			img_req_o   <= 1'b0;
			img_addr_o  <= '0;
			cfg_valid_o <= 1'b0;
			cfg_o       <= {NPORT{CFG_RST}};
		end else begin
			state       <= next_state;
			step        <= next_step;
			start_pend  <= next_start_pend;
			load_cnt    <= next_load_cnt;
			img_req_o   <= next_img_req;
			img_addr_o  <= next_img_addr;
			cfg_valid_o <= next_cfg_valid;
			cfg_o       <= next_cfg;
		end
	end

	// wishbone slave: ack one cycle after the strobe, unmapped reads give zero
	always_comb begin
		logic [WB_AW-1:0] rel;
		rel      = wb_adr_i - REG_PORT_BASE;
		next_ack = wb_req & ~wb_ack_o;
		next_dat = wb_dat_o;
		if (wb_req && !wb_ack_o) begin
			next_dat = 32'h0000_0000;
			if (wb_adr_i == REG_STATUS) begin
				next_dat[STAT_BUSY]               = (state == ST_FETCH);
				next_dat[STAT_VALID]              = cfg_valid_o;
				next_dat[STAT_CNT_LO +: 16]       = load_cnt;
			end else if (wb_adr_i >= REG_PORT_BASE && rel < WB_AW'(NPORT) * REG_PORT_STEP
					&& rel[1:0] == 2'b00) begin
				next_dat = port_word(cfg_o[rel[WB_AW-1:3]], rel[2]);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= next_ack;
			wb_dat_o <= next_dat;
		end
	end

	// checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_req))
		else $error("ack without request");
	AST_NOVALID_BUSY: assert property (img_req_o |-> !cfg_valid_o)
		else $error("fields flagged valid during load");
	AST_VALID_LAST: assert property (take && step == 3'h7 |=> cfg_valid_o && !img_req_o)
		else $error("valid not raised after last word");
	AST_LINK_P0: assert property (take && img_addr_o == IMG_LINK_P0 |=>
			cfg_o[0].fts_count == $past(img_data_i[7:0]))
		else $error("port 0 fts count wrong");
	AST_LINK_P1: assert property (take && img_addr_o == IMG_LINK_P1 |=>
			{cfg_o[1].l0s, cfg_o[1].scrambler, cfg_o[1].ppm_diff, cfg_o[1].fts_count}
			== $past(img_data_i[12:0]))
		else $error("port 1 link fields wrong");
	AST_LINK_P2: assert property (take && img_addr_o == IMG_LINK_P2 |=>
			{cfg_o[2].l0s, cfg_o[2].scrambler, cfg_o[2].ppm_diff, cfg_o[2].fts_count}
			== $past(img_data_i[12:0]))
		else $error("port 2 link fields wrong");
	AST_AMP: assert property (take && img_addr_o == IMG_AMP |=>
			cfg_o[2].amp_half == $past(img_data_i[14:10])
			&& cfg_o[0].drive_amplitude_nominal_low == $past(img_data_i[4:0])
			&& cfg_o[1].drive_amplitude_nominal_high == $past(img_data_i[9:5]))
		else $error("drive amplitude fields wrong");
	AST_DEEMPH: assert property (take && img_addr_o == IMG_DEEMPH |=>
			cfg_o[1].deemph == $past(img_data_i[4:0]) && cfg_o[1].amp_half == $past(cfg_o[1].amp_half))
		else $error("de-emphasis load wrong");
	AST_PHY: assert property (take && img_addr_o == IMG_PHY |=>
			{cfg_o[0].rx_detect, cfg_o[0].phy_latency} == $past(img_data_i[6:0]))
		else $error("phy control load wrong");
	AST_SLOT_P0: assert property (take && img_addr_o == IMG_SLOT_P0 |=>
			{cfg_o[0].tc_map, cfg_o[0].pm_scale, cfg_o[0].port_number} == $past({img_data_i[15:9],
			img_data_i[7:4]}) && {cfg_o[0].dev_init, cfg_o[0].slot_clock} == $past(img_data_i[2:1]))
		else $error("port 0 slot fields wrong");
	AST_SLOT_P1: assert property (take && img_addr_o == IMG_SLOT_P1 |=>
			{cfg_o[1].pm_scale, cfg_o[1].port_number} == $past(img_data_i[7:4])
			&& {cfg_o[1].dev_init, cfg_o[1].slot_clock, cfg_o[1].slot_impl} == $past(img_data_i[2:0]))
		else $error("port 1 slot fields wrong");
	AST_STABLE_IDLE: assert property (!img_req_o && !$past(img_req_o) |-> $stable(cfg_o))
		else $error("fields changed outside a load");

	COV_LOAD_DONE: cover property (take && step == 3'h7 ##1 cfg_valid_o);
	COV_RELOAD: cover property (wb_ack_o && wb_we_i && wb_adr_i == REG_CTRL ##[1:4] img_req_o);
	COV_STATUS_RD: cover property (wb_ack_o && !wb_we_i && wb_adr_i == REG_STATUS);
	COV_WAIT: cover property (img_req_o && !img_ack_i ##1 take);

endmodule

`default_nettype wire

/* File: rtl/pcl_pkg.sv */
// shared types and constants of the configuration image loader
package pcl_pkg;

	localparam int NPORT    = 3;
	localparam int IMG_AW   = 8;
	localparam int IMG_DW   = 16;
	localparam int WB_AW    = 8;
	localparam int NSTEP    = 8;
	localparam int STEP_W   = 3;

	// image word addresses, in load order
	localparam logic [IMG_AW-1:0] IMG_LINK_P0 = 8'h10;
	localparam logic [IMG_AW-1:0] IMG_LINK_P1 = 8'h12;
	localparam logic [IMG_AW-1:0] IMG_LINK_P2 = 8'h14;
	localparam logic [IMG_AW-1:0] IMG_AMP     = 8'h18;
	localparam logic [IMG_AW-1:0] IMG_DEEMPH  = 8'h1A;
	localparam logic [IMG_AW-1:0] IMG_PHY     = 8'h1C;
	localparam logic [IMG_AW-1:0] IMG_SLOT_P0 = 8'h20;
	localparam logic [IMG_AW-1:0] IMG_SLOT_P1 = 8'h22;

	// register byte offsets
	localparam logic [WB_AW-1:0] REG_CTRL      = 8'h00;
	localparam logic [WB_AW-1:0] REG_STATUS    = 8'h04;
	localparam logic [WB_AW-1:0] REG_PORT_BASE = 8'h10;
	localparam logic [WB_AW-1:0] REG_PORT_STEP = 8'h08;

	localparam int CTRL_RELOAD = 0;
	localparam int STAT_BUSY   = 0;
	localparam int STAT_VALID  = 1;
	localparam int STAT_CNT_LO = 16;

	// image word layouts, msb first
	typedef struct packed {
		logic [2:0] rsvd;
		logic       l0s;
		logic [1:0] scrambler;
		logic [1:0] ppm_diff;
		logic [7:0] fts_count;
	} pcl_link_word_t;

	typedef struct packed {
		logic       rsvd;
		logic [4:0] half;
		logic [4:0] nominal_high;
		logic [4:0] nominal_low;
	} pcl_amp_word_t;

	typedef struct packed {
		logic [10:0] rsvd;
		logic [4:0]  level;
	} pcl_deemph_word_t;

	typedef struct packed {
		logic [8:0] rsvd;
		logic [2:0] rx_detect;
		logic [3:0] phy_latency;
	} pcl_phy_word_t;

	typedef struct packed {
		logic [6:0] tc_map;
		logic       rsvd_hi;
		logic [1:0] pm_scale;
		logic [1:0] port_number;
		logic       rsvd_lo;
		logic       dev_init;
		logic       slot_clock;
		logic       slot_impl;
	} pcl_slot_word_t;

	// loaded fields of one port
	typedef struct packed {
		logic       slot_impl;
		logic [6:0] tc_map;
		logic [1:0] pm_scale;
		logic [1:0] port_number;
		logic       dev_init;
		logic       slot_clock;
		logic [2:0] rx_detect;
		logic [3:0] phy_latency;
		logic [4:0] deemph;
		logic [4:0] amp_half;
		logic [4:0] drive_amplitude_nominal_high;
		logic [4:0] drive_amplitude_nominal_low;
		logic       l0s;
		logic [1:0] scrambler;
		logic [1:0] ppm_diff;
		logic [7:0] fts_count;
	} pcl_port_cfg_t;

	localparam int CFG_W = $bits(pcl_port_cfg_t);
	localparam pcl_port_cfg_t CFG_RST = '0;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_FETCH = 2'b01
	} pcl_state_t;

endpackage

/* File: sim/pcl_img_mem.sv */
// behavioural configuration image memory on the loader's image port
`timescale 1ns/1ps
`default_nettype none

module pcl_img_mem
	import pcl_pkg::*;
(
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	input  wire logic                      req_i,
	input  wire logic [IMG_AW-1:0]         addr_i,
	input  wire logic                      slow_i,
	input  wire logic [7:0][IMG_DW-1:0]    img_i,
	output logic                           ack_o,
	output logic      [IMG_DW-1:0]         data_o
);
	logic [1:0] cnt;

	function automatic logic [IMG_DW-1:0] word(input logic [IMG_AW-1:0] a);
		case (a)
			IMG_LINK_P0: return img_i[0];
			IMG_LINK_P1: return img_i[1];
			IMG_LINK_P2: return img_i[2];
			IMG_AMP:     return img_i[3];
			IMG_DEEMPH:  return img_i[4];
			IMG_PHY:     return img_i[5];
			IMG_SLOT_P0: return img_i[6];
			IMG_SLOT_P1: return img_i[7];
			default:     return 16'hBAD0;
		endcase
	endfunction

	// data toggles outside the answer cycle so stale words never look valid
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o  <= 1'b0;
			cnt    <= 2'h0;
			data_o <= 16'h0000;
		end else if (req_i && !ack_o && (cnt == 2'h3 || !slow_i)) begin
			ack_o  <= 1'b1;
			data_o <= word(addr_i);
			cnt    <= 2'h0;
		end else begin
			ack_o  <= 1'b0;
			data_o <= ~data_o;
			if (req_i && !ack_o)
				cnt <= cnt + 2'h1;
		end
	end
endmodule

`default_nettype wire

/* File: sim/pcl_loader_tb.sv */
// self-checking testbench of the configuration image loader
`timescale 1ns/1ps
`default_nettype none

module pcl_loader_tb;
	import pcl_pkg::*;

	logic                          clk_i = 1'b0;
	logic                          rst_i = 1'b1;
	logic                          cyc = 1'b0, stb = 1'b0, we = 1'b0, slow = 1'b0;
	logic [WB_AW-1:0]              adr = 8'h00;
	logic [3:0]                    sel = 4'h0;
	logic [31:0]                   wdat = 32'h0, wb_dat_o, rd;
	logic                          wb_ack_o, img_req_o, img_ack_i, cfg_valid_o;
	logic [IMG_AW-1:0]             img_addr_o;
	logic [IMG_DW-1:0]             img_data_i;
	pcl_port_cfg_t [NPORT-1:0]     cfg_o;
	// words 22h,20h,1Ch,1Ah,18h,14h,12h,10h; reserved bits set in 22h,1Ch,1Ah,18h,14h, clear in 20h, mixed in 12h,10h, flipped in the inverse
	logic [7:0][15:0]              img_a = {16'hA12B, 16'h5ED6, 16'hFF9A, 16'hFFE5, 16'hFFFF, 16'hF00F, 16'h5A3C, 16'hA5C3};
	logic [7:0][15:0]              img = img_a;
	int                            n_errors = 0, n_checks = 0;

	always #12.5 clk_i = ~clk_i;

	pcl_loader i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.img_req_o(img_req_o), .img_addr_o(img_addr_o), .img_ack_i(img_ack_i), .img_data_i(img_data_i),
		.cfg_o(cfg_o), .cfg_valid_o(cfg_valid_o));

	pcl_img_mem i_mem (.clk_i(clk_i), .rst_i(rst_i), .req_i(img_req_o), .addr_i(img_addr_o),
		.slow_i(slow), .img_i(img), .ack_o(img_ack_i), .data_o(img_data_i));

	task automatic test_done;
		if (n_errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// classic single cycle, held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50)
			n_errors++;
		q = wb_dat_o;
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
	endtask

	function automatic pcl_port_cfg_t exp_cfg(input int p, input logic [7:0][15:0] w);
		pcl_port_cfg_t e;
		logic [15:0] l, s;
		l = w[p];
		s = (p == 0) ? w[6] : (p == 1) ? w[7] : 16'h0000;
		e = '0;
		e.fts_count = l[7:0]; e.ppm_diff = l[9:8]; e.scrambler = l[11:10]; e.l0s = l[12];
		e.drive_amplitude_nominal_low = w[3][4:0]; e.drive_amplitude_nominal_high = w[3][9:5];
		e.amp_half = w[3][14:10]; e.deemph = w[4][4:0]; e.phy_latency = w[5][3:0]; e.rx_detect = w[5][6:4];
		e.slot_clock = s[1]; e.dev_init = s[2]; e.port_number = s[5:4]; e.pm_scale = s[7:6];
		e.tc_map = s[15:9]; e.slot_impl = (p == 1) && s[0];
		return e;
	endfunction

	// bounded wait for completion, then every port against the image
	task automatic t_load(input logic [7:0][15:0] w);
		int n;
		n = 0;
		while (cfg_valid_o !== 1'b1 && n < 400) begin
			@(posedge clk_i);
			n++;
		end
		check("load done", cfg_valid_o, 1'b1);
		check("port0", cfg_o[0], exp_cfg(0, w));
		check("port1", cfg_o[1], exp_cfg(1, w));
		check("port2", cfg_o[2], exp_cfg(2, w));
	endtask

	task automatic t_regs;
		pcl_port_cfg_t e;
		wb(1'b0, REG_STATUS, 32'h0, rd);
		check("status", rd, 32'h0001_0002);
		for (int p = 0; p < NPORT; p++) begin
			e = exp_cfg(p, img_a);
			wb(1'b0, REG_PORT_BASE + 8'(8 * p), 32'h0, rd);
			check("port low", rd, e[31:0]);
			wb(1'b0, REG_PORT_BASE + 8'(8 * p + 4), 32'h0, rd);
			check("port high", rd, {10'h000, e[53:32]});
		end
		wb(1'b1, 8'hF0, 32'hFFFF_FFFF, rd);
		wb(1'b0, 8'hF0, 32'h0, rd);
		check("unmapped", rd, 32'h0);
	endtask

	// slow memory; old port 0 fields still stand early in the load, and valid stays low until the whole load lands
	task automatic t_reload;
		img <= ~img_a;
		slow <= 1'b1;
		wb(1'b1, REG_CTRL, 32'h1, rd);
		wb(1'b0, REG_STATUS, 32'h0, rd);
		check("status busy", rd, 32'h0001_0001);
		check("valid in reload", cfg_valid_o, 1'b0);
		check("old port0", cfg_o[0], exp_cfg(0, img_a));
		wb(1'b1, REG_CTRL, 32'h1, rd);
		t_load(~img_a);
		repeat (60) @(posedge clk_i);
		wb(1'b0, REG_STATUS, 32'h0, rd);
		check("status count", rd, 32'h0002_0002);
	endtask

	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		check("valid at reset", cfg_valid_o, 1'b0);
		check("cfg0 at reset", cfg_o[0], CFG_RST);
		check("cfg1 at reset", cfg_o[1], CFG_RST);
		check("cfg2 at reset", cfg_o[2], CFG_RST);
		t_load(img_a);
		t_regs;
		t_reload;
		test_done;
	end

	initial begin
		repeat (5000) @(posedge clk_i);
		n_errors++;
		test_done;
	end
endmodule

`default_nettype wire
